/* rtl/upcr_consts.vh */
// Purpose: Shared offsets, field positions, reset values and sizes.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef UPCR_CONSTS_VH
`define UPCR_CONSTS_VH

`define UPCR_OFF_PWR        8'h3c
`define UPCR_OFF_XCVR       8'h40
`define UPCR_OFF_LINE       8'h44
`define UPCR_OFF_IRQ_STAT   8'h48
`define UPCR_OFF_IRQ_MASK   8'h4c

`define UPCR_PWR_VALID_BIT  8
`define UPCR_XCVR_PD_BIT    18
`define UPCR_XCVR_RST_BIT   13
`define UPCR_XCVR_RES_BIT   12
`define UPCR_XCVR_FLT_HI    11
`define UPCR_XCVR_FLT_LO    8
`define UPCR_XCVR_HWRES_BIT 7
`define UPCR_XCVR_CFG_HI    6
`define UPCR_XCVR_CFG_LO    4

`define UPCR_RESET_VALUE    32'h0000_0000
`define UPCR_LS_SE0         2'h0
`define UPCR_LS_J           2'h1
`define UPCR_LS_K           2'h2
`define UPCR_FLT_MAX_LOG    15
`define UPCR_RESP_OKAY      2'h0
`define UPCR_RESP_SLVERR    2'h2

`endif

/* rtl/upcr_line_filter.v */
// Purpose: Line-state change filter with a power-of-two hold count.
// Assumes: Line state is synchronous to aclk.
// Notes:   A change is passed only after it has stood for 2**log2 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "upcr_consts.vh"

module upcr_line_filter (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Control
    input  wire [3:0]  log2_count,
    // Line state
    input  wire [1:0]  line_raw,
    output reg  [1:0]  line_filt_r
);

    reg  [1:0]  cand_r;
    reg  [15:0] cnt_r;
    wire [15:0] target;

    // Target of 2**n cycles; n = 0 passes after one steady cycle.
    assign target = 16'h0001 << log2_count;

    // A fresh change reloads the count so only steady levels pass.
    always @(posedge aclk) begin
        if (!aresetn) begin
            cand_r      <= `UPCR_LS_SE0;
            cnt_r       <= 16'h0000;
            line_filt_r <= `UPCR_LS_SE0;
        end else if (line_raw != cand_r) begin
            cand_r <= line_raw;
            cnt_r  <= 16'h0001;
        end else if (cand_r != line_filt_r) begin
            if (cnt_r >= target) begin
                line_filt_r <= cand_r;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

endmodule
`default_nettype wire

/* rtl/upcr_suspend_ctl.v */
// Purpose: Suspend controller that resumes on filtered line activity.
// Assumes: Suspend request comes from the interface module logic.
// Notes:   Reports the cause of each SE0 or K automatic resume as a pulse.
`timescale 1ns/100ps
`default_nettype none
`include "upcr_consts.vh"

module upcr_suspend_ctl (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Control
    input  wire        hw_resume_en,
    input  wire        suspend_req,
    input  wire [1:0]  line_filt,
    // Status
    output reg         suspended_r,
    output reg         resume_se0_r,
    output reg         resume_k_r
);

    localparam ST_RUN  = 2'b01;
    localparam ST_SUSP = 2'b10;

    reg [1:0] state_r;

    // Only hardware mode leaves suspend; otherwise software polls.
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r      <= ST_RUN;
            suspended_r  <= 1'b0;
            resume_se0_r <= 1'b0;
            resume_k_r   <= 1'b0;
        end else begin
            resume_se0_r <= 1'b0;
            resume_k_r   <= 1'b0;
            case (state_r)
                ST_RUN: begin
                    if (suspend_req) begin
                        state_r     <= ST_SUSP;
                        suspended_r <= 1'b1;
                    end
                end
                ST_SUSP: begin
                    if (hw_resume_en && line_filt != `UPCR_LS_J) begin
                        state_r      <= ST_RUN;
                        suspended_r  <= 1'b0;
                        resume_se0_r <= (line_filt == `UPCR_LS_SE0);
                        resume_k_r   <= (line_filt == `UPCR_LS_K);
                    end
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* rtl/upcr_top.v */
// Purpose: AXI4-Lite register block for USB transceiver control.
// Assumes: One clock aclk, synchronous active-low reset aresetn.
// Notes:   Single outstanding write and read; all outputs registered.
`timescale 1ns/100ps
`default_nettype none
`include "upcr_consts.vh"

module upcr_top (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Transceiver side
    input  wire [1:0]  line_state,
    input  wire        suspend_req,
    output reg  [2:0]  transceiver_config_pins,
    output reg         wide_port_a_pd_dis,
    output reg         wide_port_b_pd_dis,
    output reg  [7:0]  power_signal_data,
    output reg         power_signal_valid,
    // Interrupt
    output reg         irq
);

    // Register state.
    reg  [7:0]  pwr_data_r;
    reg         pwr_valid_r;
    reg         pd_dis_r;
    reg         flag_se0_r;
    reg         flag_k_r;
    reg  [3:0]  flt_log_r;
    reg         hw_res_r;
    reg  [2:0]  cfg_r;
    reg  [2:0]  irq_stat_r;
    reg  [2:0]  irq_mask_r;

    // Write channel capture.
    reg  [7:0]  aw_addr_r;
    reg         aw_have_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg         w_have_r;

    wire [1:0]  line_filt;
    wire        suspended;
    wire        res_se0;
    wire        res_k;
    reg  [1:0]  line_filt_q;
    wire        line_evt;
    wire        do_write;
    wire        do_read;
    wire [7:0]  ar_word;
    reg  [31:0] wmerged;
    reg  [31:0] rd_val;
    reg         rd_ok;
    reg         wr_ok;

    upcr_line_filter u_filt (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .log2_count  (flt_log_r),
        .line_raw    (line_state),
        .line_filt_r (line_filt)
    );

    upcr_suspend_ctl u_susp (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .hw_resume_en (hw_res_r),
        .suspend_req  (suspend_req),
        .line_filt    (line_filt),
        .suspended_r  (suspended),
        .resume_se0_r (res_se0),
        .resume_k_r   (res_k)
    );

    assign line_evt = (line_filt != line_filt_q);
    assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
    assign do_read  = s_axi_arvalid && s_axi_arready;
    // Reads decode the word address, like writes, so low bits are ignored.
    assign ar_word  = {s_axi_araddr[7:2], 2'b00};

    // Merge strobed write bytes over the addressed register's value.
    always @* begin
        wmerged = rd_val_w(aw_addr_r);
        if (w_strb_r[0]) wmerged[7:0]   = w_data_r[7:0];
        if (w_strb_r[1]) wmerged[15:8]  = w_data_r[15:8];
        if (w_strb_r[2]) wmerged[23:16] = w_data_r[23:16];
        if (w_strb_r[3]) wmerged[31:24] = w_data_r[31:24];
    end

    // Register image for reads; reserved bits read as zero.
    function [31:0] rd_val_w;
        input [7:0] a;
        begin
            rd_val_w = `UPCR_RESET_VALUE;
            if (a == `UPCR_OFF_PWR) begin
                rd_val_w[8:0] = {pwr_valid_r, pwr_data_r};
            end else if (a == `UPCR_OFF_XCVR) begin
                rd_val_w[18]  = pd_dis_r;
                rd_val_w[13]  = flag_se0_r;
                rd_val_w[12]  = flag_k_r;
                rd_val_w[11:8] = flt_log_r;
                rd_val_w[7]   = hw_res_r;
                rd_val_w[6:4] = cfg_r;
            end else if (a == `UPCR_OFF_LINE) begin
                rd_val_w[2:0] = {suspended, line_filt};
            end else if (a == `UPCR_OFF_IRQ_STAT) begin
                rd_val_w[2:0] = irq_stat_r;
            end else if (a == `UPCR_OFF_IRQ_MASK) begin
                rd_val_w[2:0] = irq_mask_r;
            end
        end
    endfunction

    // Address decode for legality.
    always @* begin
        rd_val = rd_val_w(ar_word);
        rd_ok  = (ar_word == `UPCR_OFF_PWR) ||
                 (ar_word == `UPCR_OFF_XCVR) ||
                 (ar_word == `UPCR_OFF_LINE) ||
                 (ar_word == `UPCR_OFF_IRQ_STAT) ||
                 (ar_word == `UPCR_OFF_IRQ_MASK);
        wr_ok  = (aw_addr_r == `UPCR_OFF_PWR) ||
                 (aw_addr_r == `UPCR_OFF_XCVR) ||
                 (aw_addr_r == `UPCR_OFF_IRQ_STAT) ||
                 (aw_addr_r == `UPCR_OFF_IRQ_MASK);
    end

    // Write channels are taken independently, in either order.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `UPCR_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready;
            s_axi_wready  <= !w_have_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `UPCR_RESP_OKAY : `UPCR_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
            end
        end
    end

    // Read channel: one read in flight; data is latched at acceptance.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `UPCR_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
                             !s_axi_arvalid ? 1'b1 :
                             (!s_axi_rvalid && !s_axi_arready);
            if (do_read) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {rd_val[31:3],
                                  (ar_word == `UPCR_OFF_IRQ_STAT) ?
                                  (irq_stat_r | {res_k, res_se0,
                                  line_evt}) : rd_val[2:0]};
                s_axi_rresp   <= rd_ok ? `UPCR_RESP_OKAY :
                                 `UPCR_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
            end
        end
    end

    // Control and flag registers; hardware set beats software clear.
    always @(posedge aclk) begin
        if (!aresetn) begin
            pwr_data_r  <= 8'h00;
            pwr_valid_r <= 1'b0;
            pd_dis_r    <= 1'b0;
            flag_se0_r  <= 1'b0;
            flag_k_r    <= 1'b0;
            flt_log_r   <= 4'h0;
            hw_res_r    <= 1'b0;
            cfg_r       <= 3'h0;
            irq_mask_r  <= 3'h0;
            line_filt_q <= `UPCR_LS_SE0;
        end else begin
            line_filt_q <= line_filt;
            if (do_write && aw_addr_r == `UPCR_OFF_PWR) begin
                pwr_data_r  <= wmerged[7:0];
                pwr_valid_r <= wmerged[`UPCR_PWR_VALID_BIT];
            end
            if (do_write && aw_addr_r == `UPCR_OFF_XCVR) begin
                pd_dis_r   <= wmerged[`UPCR_XCVR_PD_BIT];
                flt_log_r  <= wmerged[11:8];
                hw_res_r   <= wmerged[`UPCR_XCVR_HWRES_BIT];
                cfg_r      <= wmerged[6:4];
                flag_se0_r <= wmerged[`UPCR_XCVR_RST_BIT];
                flag_k_r   <= wmerged[`UPCR_XCVR_RES_BIT];
            end
            if (do_write && aw_addr_r == `UPCR_OFF_IRQ_MASK) begin
                irq_mask_r <= wmerged[2:0];
            end
            if (res_se0) begin
                flag_se0_r <= 1'b1;
            end
            if (res_k) begin
                flag_k_r <= 1'b1;
            end
        end
    end

    // Sticky interrupt status, cleared by a read; new events win.
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= 3'h0;
        end else if (do_read && ar_word == `UPCR_OFF_IRQ_STAT) begin
            irq_stat_r <= {res_k, res_se0, line_evt};
        end else begin
            irq_stat_r <= irq_stat_r | {res_k, res_se0, line_evt};
        end
    end

    // Output flops so pins never glitch on decode.
    always @(posedge aclk) begin
        if (!aresetn) begin
            transceiver_config_pins <= 3'h0;
            wide_port_a_pd_dis      <= 1'b0;
            wide_port_b_pd_dis      <= 1'b0;
            power_signal_data       <= 8'h00;
            power_signal_valid      <= 1'b0;
            irq                     <= 1'b0;
        end else begin
            transceiver_config_pins <= cfg_r;
            wide_port_a_pd_dis      <= pd_dis_r;
            wide_port_b_pd_dis      <= pd_dis_r;
            power_signal_data       <= pwr_data_r;
            power_signal_valid      <= pwr_valid_r;
            irq                     <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the transceiver control block.
// Assumes: The model scripts the line; bus tasks wait for each answer.
// Notes:   A filter of 2**4 cycles keeps register reads inside it.
`timescale 1ns/100ps
`default_nettype none
`include "upcr_consts.vh"
module testbench;
    localparam logic [1:0] okay = `UPCR_RESP_OKAY;
    localparam logic [1:0] slverr = `UPCR_RESP_SLVERR;
    localparam logic [7:0] a_pwr = `UPCR_OFF_PWR;
    localparam logic [7:0] a_ctl = `UPCR_OFF_XCVR;
    localparam logic [7:0] a_line = `UPCR_OFF_LINE;
    localparam logic [7:0] a_ist = `UPCR_OFF_IRQ_STAT;
    localparam logic [7:0] a_imk = `UPCR_OFF_IRQ_MASK;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0, pwr_d;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        pd_a, pd_b, pwr_v, suspend_req;
    logic [1:0]  bresp, rresp, line_state;
    logic [2:0]  cfg;
    int          n_fail = 0, checks = 0;
    // Free-running clock at 100 MHz.
    always #5 aclk = ~aclk;
    upcr_top dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .line_state(line_state), .suspend_req(suspend_req),
        .transceiver_config_pins(cfg), .wide_port_a_pd_dis(pd_a),
        .wide_port_b_pd_dis(pd_b), .power_signal_data(pwr_d),
        .power_signal_valid(pwr_v), .irq(irq)
    );
    upcr_xcvr_model xcvr (
        .aclk(aclk), .line_state(line_state), .suspend_req(suspend_req)
    );
    task automatic close_out();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value t=%0t %s: %h not %h", $time, what, got, exp);
        end
    endtask
    // Each channel is held until its own ready; only the watchdog ends a wait.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk(32'(bresp), 32'(er), "bresp");
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rready <= 1'h0;
        chk(rdata, exp, "rdata");
        chk(32'(rresp), 32'(er), "rresp");
    endtask
    task automatic t_reset();
        rchk(a_pwr, 32'h0, okay);
        rchk(a_ctl, 32'h0, okay);
        chk(32'({pd_a, pd_b, cfg, pwr_v, pwr_d}), 32'h0, "pins");
    endtask
    // Byte strobes must leave the other byte of the register alone.
    task automatic t_power();
        wr(a_pwr, 32'hffff_ffff, 4'hf, okay);
        rchk(a_pwr, 32'h0000_01ff, okay);
        chk(32'({pwr_v, pwr_d}), 32'h1ff, "pwr");
        wr(a_pwr, 32'h0000_00a5, 4'h1, okay);
        wr(a_pwr, 32'h0, 4'h2, okay);
        rchk(a_pwr, 32'h0000_00a5, okay);
    endtask
    task automatic t_ctrl();
        wr(a_ctl, 32'hffff_ffff, 4'hf, okay);
        rchk(a_ctl, 32'h0004_3ff0, okay);
        chk(32'({pd_a, pd_b}), 32'h3, "pd");
        for (int k = 0; k < 8; k++) begin
            wr(a_ctl, 32'(k) << 4, 4'hf, okay);
            repeat (3) @(posedge aclk);
            chk(32'(cfg), 32'(k), "cfg");
        end
        chk(32'({pd_a, pd_b}), 32'h0, "pd");
    endtask
    // A blip shorter than the window must never reach the filtered state.
    task automatic t_filter();
        wr(a_ctl, 32'h0000_0400, 4'hf, okay);
        xcvr.set_line(`UPCR_LS_K, 6);
        xcvr.set_line(`UPCR_LS_J, 20);
        rchk(a_line, 32'h1, okay);
        xcvr.set_line(`UPCR_LS_K, 8);
        rchk(a_line, 32'h1, okay);
        repeat (12) @(posedge aclk);
        rchk(a_line, 32'h2, okay);
        xcvr.set_line(`UPCR_LS_J, 40);
    endtask
    task automatic t_resume();
        wr(a_ctl, 32'h0000_0080, 4'hf, okay);
        wr(a_imk, 32'hffff_ffff, 4'hf, okay);
        rchk(a_imk, 32'h7, okay);
        rchk(a_ist, 32'h1, okay);
        xcvr.suspend_pulse();
        rchk(a_line, 32'h5, okay);
        xcvr.set_line(`UPCR_LS_K, 6);
        xcvr.set_line(`UPCR_LS_J, 6);
        rchk(a_line, 32'h1, okay);
        rchk(a_ctl, 32'h0000_1080, okay);
        chk(32'(irq), 32'h1, "irq");
        rchk(a_ist, 32'h5, okay);
        repeat (3) @(posedge aclk);
        chk(32'(irq), 32'h0, "irq");
        xcvr.suspend_pulse();
        xcvr.set_line(`UPCR_LS_SE0, 6);
        xcvr.set_line(`UPCR_LS_J, 6);
        rchk(a_ctl, 32'h0000_3080, okay);
        chk(32'(irq), 32'h1, "irq");
        wr(a_imk, 32'h0, 4'hf, okay);
        repeat (3) @(posedge aclk);
        chk(32'(irq), 32'h0, "irq");
        rchk(a_ist, 32'h3, okay);
        wr(a_ctl, 32'h0000_0080, 4'hf, okay);
        rchk(a_ctl, 32'h0000_0080, okay);
    endtask
    // Without hardware resume the block stays suspended for polling.
    task automatic t_poll();
        wr(a_ctl, 32'h0, 4'hf, okay);
        xcvr.suspend_pulse();
        xcvr.set_line(`UPCR_LS_K, 6);
        rchk(a_line, 32'h6, okay);
        rchk(a_ctl, 32'h0, okay);
        xcvr.set_line(`UPCR_LS_J, 6);
    endtask
    task automatic t_errors();
        for (int i = 0; i < 4; i++)
            rchk(8'(i) * 8'h50, 32'h0, slverr);
        wr(8'h50, 32'hffff_ffff, 4'hf, slverr);
        wr(a_line, 32'hffff_ffff, 4'hf, slverr);
        rchk(a_line, 32'h5, okay);
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_power();
        t_ctrl();
        t_filter();
        t_resume();
        t_poll();
        t_errors();
        close_out();
    end
    // A hang counts against the run and ends it the same way.
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        close_out();
    end
endmodule
bind upcr_top upcr_checker u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .transceiver_config_pins,
    .wide_port_a_pd_dis, .wide_port_b_pd_dis, .power_signal_valid, .irq
);
`default_nettype wire

/* tb/upcr_checker.sv */
// Purpose: Port-level assertions for the transceiver control block.
// Assumes: Bound to upcr_top; one clock, synchronous active-low reset.
// Notes:   Windows follow the hand-over timing of the register bus.
`timescale 1ns/100ps
`default_nettype none
`include "upcr_consts.vh"
module upcr_checker (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Bus handshakes
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic       s_axi_rvalid,
    // Device pins
    input wire logic [2:0] transceiver_config_pins,
    input wire logic       wide_port_a_pd_dis,
    input wire logic       wide_port_b_pd_dis,
    input wire logic       power_signal_valid,
    input wire logic       irq
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [2:0] wr_age_r;
    logic [2:0] rd_age_r;
    wire        odd_addr = s_axi_araddr < 8'h3c || s_axi_araddr > 8'h4f;
    // Config pins and power valid may only move, and irq only fall, shortly after software touched a register.
    always_ff @(posedge aclk) begin
        if (!aresetn || (s_axi_wvalid && s_axi_wready)) wr_age_r <= 3'h0;
        else if (wr_age_r != 3'h7) wr_age_r <= wr_age_r + 3'h1;
        if (!aresetn || (s_axi_arvalid && s_axi_arready)) rd_age_r <= 3'h0;
        else if (rd_age_r != 3'h7) rd_age_r <= rd_age_r + 3'h1;
    end
    // Both write channels are offered together by the bench.
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_answer_a: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data late");
    wr_quiet_a: assert property (s_axi_bvalid |-> !s_axi_awready
        && !s_axi_wready) else $error("write accepted while busy");
    rd_quiet_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    bad_read_a: assert property (rd_take ##0 odd_addr |=>
        s_axi_rresp == `UPCR_RESP_SLVERR) else $error("no slave error");
    pd_pair_a: assert property (wide_port_a_pd_dis ==
        wide_port_b_pd_dis) else $error("pulldown pins differ");
    cfg_cause_a: assert property ($changed(transceiver_config_pins) |->
        wr_age_r < 3'h6) else $error("config pins moved alone");
    pwr_cause_a: assert property ($changed(power_signal_valid) |->
        wr_age_r < 3'h6) else $error("power valid moved alone");
    irq_drop_a: assert property ($fell(irq) |-> rd_age_r < 3'h6
        || wr_age_r < 3'h6) else $error("interrupt dropped alone");
endmodule
`default_nettype wire

/* tb/upcr_xcvr_model.sv */
// Purpose: Behavioural transceiver driving line state and suspend.
// Assumes: Changes land just after a rising edge of aclk.
// Notes:   The hold count gives a prompt or a slow line response.
`timescale 1ns/100ps
`default_nettype none
`include "upcr_consts.vh"
module upcr_xcvr_model (
    // Clock
    input  wire logic      aclk,
    // Line side
    output var logic [1:0] line_state,
    output var logic       suspend_req
);
    // An idle bus sits in J with no suspend request.
    initial begin
        line_state = `UPCR_LS_J;
        suspend_req = 1'h0;
    end
    // Move the line and keep it there for a number of cycles.
    task automatic set_line(input logic [1:0] ls, input int hold);
        @(posedge aclk);
        line_state <= ls;
        repeat (hold) @(posedge aclk);
    endtask
    // A short request, since a held level would re-enter suspend.
    task automatic suspend_pulse();
        @(posedge aclk);
        suspend_req <= 1'h1;
        @(posedge aclk);
        suspend_req <= 1'h0;
        repeat (4) @(posedge aclk);
    endtask
endmodule
`default_nettype wire
